// [fsr_device.sv]
// Flash device end: suspend and resume, unique id, security register erase and program
`timescale 1ns/1ps
module fsr_device #(
  // Arbitrary id value
  parameter logic [127:0] UID_VALUE = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0
) (
  fsr_if.dev         link,
  input  wire logic  mclk,
  input  wire logic  rst_n,
  input  wire logic  [2:0] otp_lock_bits,
  input  wire logic  array_op_start,
  input  wire logic  array_op_erase,
  input  wire logic  [1:0] rd_sel,
  input  wire logic  [9:0] rd_off,
  output logic       [7:0] rd_data,
  output logic       busy_flag,
  output logic       write_latch,
  output logic       [1:0] paused_flags
);
  function automatic logic [1:0] sr_sel(input logic [23:0] a);
    if (a[23:16] == 8'h00 && a[11:10] == 2'b00 &&
        a[15:12] >= fsr_pkg::SR_SEL_MIN && a[15:12] <= fsr_pkg::SR_SEL_MAX)
      return a[13:12];
    return 2'b00;
  endfunction : sr_sel

  function automatic logic [11:0] mem_index(input logic [1:0] sel, input logic [9:0] off);
    return {2'(sel - 2'b01), off};
  endfunction : mem_index

  // Link clock domain
  logic         frame_rst_n;
  logic [7:0]   cnt_r, cnt_nxt;
  logic [31:0]  sh_r, sh_nxt;
  logic [7:0]   db_r, db_nxt;
  logic [7:0]   kcnt_r, kcnt_nxt;
  logic         ex8_r, ex8_nxt;
  logic         ex32_r, ex32_nxt;
  logic         ge40_r, ge40_nxt;
  logic [255:0] vmask_r, vmask_nxt;
  logic         buf_we;
  logic [7:0]   buf_idx;
  logic         so_r, so_nxt;
  logic [6:0]   uid_pos;
  logic [7:0]   pbuf [0:255];

  assign frame_rst_n = rst_n & ~link.cs_n;

  always_comb begin
    cnt_nxt   = (cnt_r == fsr_pkg::UID_WRAP) ? fsr_pkg::BITS_DATA : 8'(cnt_r + 8'h01);
    sh_nxt    = (cnt_r < fsr_pkg::BITS_ADDR) ? {sh_r[30:0], link.si} : sh_r;
    db_nxt    = {db_r[6:0], link.si};
    kcnt_nxt  = (cnt_r == 8'h00) ? 8'h00 : kcnt_r;
    ex8_nxt   = (cnt_r == 8'(fsr_pkg::BITS_OP - 8'h01));
    ex32_nxt  = (cnt_r == 8'(fsr_pkg::BITS_ADDR - 8'h01));
    ge40_nxt  = (cnt_r == 8'h00) ? 1'b0 : (ge40_r | (cnt_r == 8'(fsr_pkg::BITS_DATA - 8'h01)));
    vmask_nxt = (cnt_r == 8'h00) ? '0 : vmask_r;
    buf_idx   = 8'(sh_r[7:0] + kcnt_r);
    buf_we    = 1'b0;
    // Bytes past one page wrap onto its start
    if (cnt_r >= 8'(fsr_pkg::BITS_DATA - 8'h01) && cnt_r[2:0] == 3'h7) begin
      buf_we             = 1'b1;
      vmask_nxt[buf_idx] = 1'b1;
      kcnt_nxt           = 8'(kcnt_r + 8'h01);
    end
  end

  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Frame results survive deselect so the mclk side can read them
  always_ff @(posedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      sh_r    <= 32'h0000_0000;
      db_r    <= 8'h00;
      kcnt_r  <= 8'h00;
      ex8_r   <= 1'b0;
      ex32_r  <= 1'b0;
      ge40_r  <= 1'b0;
      vmask_r <= '0;
    end else begin
      sh_r    <= sh_nxt;
      db_r    <= db_nxt;
      kcnt_r  <= kcnt_nxt;
      ex8_r   <= ex8_nxt;
      ex32_r  <= ex32_nxt;
      ge40_r  <= ge40_nxt;
      vmask_r <= vmask_nxt;
    end
  end

  always_ff @(posedge link.sclk) begin
    if (buf_we) begin
      pbuf[buf_idx] <= db_nxt;
    end
  end

  always_comb begin
    uid_pos = 7'(cnt_r - fsr_pkg::BITS_DATA);
    so_nxt  = 1'b0;
    if (sh_r[31:24] == fsr_pkg::OP_UID && cnt_r >= fsr_pkg::BITS_DATA) begin
      so_nxt = UID_VALUE[~uid_pos];
    end
  end

  always_ff @(negedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      so_r <= 1'b0;
    end else begin
      so_r <= so_nxt;
    end
  end

  assign link.so = so_r;

  // Internal clock domain
  fsr_pkg::fsr_dev_state_t state_r, state_nxt;
  logic [2:0]  cs_s_r, cs_s_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  logic [10:0] idx_r, idx_nxt;
  logic [1:0]  sel_r, sel_nxt;
  logic [1:0]  page_r, page_nxt;
  logic        lat_r, lat_nxt;
  logic        arm_r, arm_nxt;
  logic        busy_nxt;
  logic [1:0]  paused_nxt;
  logic [7:0]  rd_nxt;
  logic        frame_end;
  logic [1:0]  f_sel;
  logic        f_ok;
  logic        mem_we;
  logic [11:0] mem_wa;
  logic [7:0]  mem_wd;
  logic [7:0]  mem [0:3071];

  assign frame_end = cs_s_r[1] & ~cs_s_r[2];
  assign f_sel     = sr_sel(sh_r[23:0]);
  assign f_ok      = (f_sel != 2'b00) && !otp_lock_bits[2'(f_sel - 2'b01)] && lat_r;

  always_comb begin
    cs_s_nxt  = {cs_s_r[1:0], link.cs_n};
    state_nxt = state_r;
    tmr_nxt   = tmr_r;
    idx_nxt   = idx_r;
    sel_nxt   = sel_r;
    page_nxt  = page_r;
    lat_nxt   = lat_r;
    arm_nxt   = arm_r;
    mem_we    = 1'b0;
    mem_wa    = mem_index(sel_r, idx_r[9:0]);
    mem_wd    = 8'hFF;
    case (state_r)
      fsr_pkg::ST_IDLE: begin
        if (array_op_start) begin
          state_nxt = array_op_erase ? fsr_pkg::ST_AERASE : fsr_pkg::ST_APROG;
          tmr_nxt   = array_op_erase ? fsr_pkg::AE_CYC : fsr_pkg::AP_CYC;
        end
      end
      fsr_pkg::ST_SPROG: begin
        // One page offset per cycle; timer outlasts the walk
        if (idx_r < fsr_pkg::PAGE_BYTES) begin
          mem_we  = vmask_r[idx_r[7:0]];
          mem_wa  = mem_index(sel_r, {page_r, idx_r[7:0]});
          mem_wd  = pbuf[idx_r[7:0]];
          idx_nxt = 11'(idx_r + 11'h001);
        end
      end
      fsr_pkg::ST_SERASE: begin
        if (idx_r < fsr_pkg::SR_BYTES) begin
          mem_we  = 1'b1;
          idx_nxt = 11'(idx_r + 11'h001);
        end
      end
      default: begin
      end
    endcase
    if (state_r == fsr_pkg::ST_APROG || state_r == fsr_pkg::ST_AERASE ||
        state_r == fsr_pkg::ST_SPROG || state_r == fsr_pkg::ST_SERASE) begin
      tmr_nxt = 16'(tmr_r - 16'h0001);
      if (tmr_r == 16'h0001) begin
        state_nxt = fsr_pkg::ST_IDLE;
      end
    end
    // Frame data is static here: the link clock stops while deselected
    if (frame_end) begin
      arm_nxt = 1'b0;
      if (ex8_r) begin
        case (sh_r[7:0])
          fsr_pkg::OP_WENA: lat_nxt = 1'b1;
          fsr_pkg::OP_WRDI: lat_nxt = 1'b0;
          fsr_pkg::OP_PAUSE: begin
            // A pause in the last timer cycle is ignored
            if (tmr_r > 16'h0001) begin
              if (state_r == fsr_pkg::ST_APROG) state_nxt = fsr_pkg::ST_PPROG;
              if (state_r == fsr_pkg::ST_AERASE) state_nxt = fsr_pkg::ST_PERASE;
              if (state_r == fsr_pkg::ST_APROG || state_r == fsr_pkg::ST_AERASE) begin
                tmr_nxt = tmr_r;
              end
            end
          end
          fsr_pkg::OP_CONT: begin
            if (state_r == fsr_pkg::ST_PPROG) state_nxt = fsr_pkg::ST_APROG;
            if (state_r == fsr_pkg::ST_PERASE) state_nxt = fsr_pkg::ST_AERASE;
          end
          fsr_pkg::OP_RSTEN: arm_nxt = 1'b1;
          fsr_pkg::OP_RST: begin
            if (arm_r) begin
              state_nxt = fsr_pkg::ST_IDLE;
              tmr_nxt   = 16'h0000;
              lat_nxt   = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end else if (state_r == fsr_pkg::ST_IDLE && f_ok) begin
        if (ex32_r && sh_r[31:24] == fsr_pkg::OP_SRER) begin
          state_nxt = fsr_pkg::ST_SERASE;
          tmr_nxt   = fsr_pkg::SE_CYC;
          idx_nxt   = 11'h000;
          sel_nxt   = f_sel;
          lat_nxt   = 1'b0;
        end else if (ge40_r && sh_r[31:24] == fsr_pkg::OP_SRPG) begin
          state_nxt = fsr_pkg::ST_SPROG;
          tmr_nxt   = fsr_pkg::PP_CYC;
          idx_nxt   = 11'h000;
          sel_nxt   = f_sel;
          page_nxt  = sh_r[9:8];
          lat_nxt   = 1'b0;
        end
      end
    end
    busy_nxt   = (state_nxt == fsr_pkg::ST_APROG) || (state_nxt == fsr_pkg::ST_AERASE) ||
                 (state_nxt == fsr_pkg::ST_SPROG) || (state_nxt == fsr_pkg::ST_SERASE);
    paused_nxt = {state_nxt == fsr_pkg::ST_PPROG, state_nxt == fsr_pkg::ST_PERASE};
    rd_nxt     = (rd_sel == 2'b00) ? 8'h00 : mem[mem_index(rd_sel, rd_off)];
  end

  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Power-on reset drops any paused work
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s_r       <= fsr_pkg::CS_SYNC_RST;
      state_r      <= fsr_pkg::ST_IDLE;
      tmr_r        <= 16'h0000;
      idx_r        <= 11'h000;
      sel_r        <= 2'b01;
      page_r       <= 2'b00;
      lat_r        <= 1'b0;
      arm_r        <= 1'b0;
      busy_flag    <= 1'b0;
      write_latch  <= 1'b0;
      paused_flags <= 2'b00;
      rd_data      <= 8'h00;
    end else begin
      cs_s_r       <= cs_s_nxt;
      state_r      <= state_nxt;
      tmr_r        <= tmr_nxt;
      idx_r        <= idx_nxt;
      sel_r        <= sel_nxt;
      page_r       <= page_nxt;
      lat_r        <= lat_nxt;
      arm_r        <= arm_nxt;
      busy_flag    <= busy_nxt;
      write_latch  <= lat_nxt;
      paused_flags <= paused_nxt;
      rd_data      <= rd_nxt;
    end
  end
endmodule : fsr_device

// [fsr_pkg.sv]
// Shared constants and state types for the suspend, unique id and security register logic
package fsr_pkg;
  localparam logic [7:0] OP_WENA  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_PAUSE = 8'h75;
  localparam logic [7:0] OP_CONT  = 8'h7A;
  localparam logic [7:0] OP_UID   = 8'h4B;
  localparam logic [7:0] OP_SRER  = 8'h44;
  localparam logic [7:0] OP_SRPG  = 8'h42;
  localparam logic [7:0] OP_RSTEN = 8'h66;
  localparam logic [7:0] OP_RST   = 8'h99;
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_PP    = 8'h02;
  localparam logic [7:0] OP_QPP   = 8'h32;
  localparam logic [7:0] OP_SE    = 8'h20;
  localparam logic [7:0] OP_BE32  = 8'h52;
  localparam logic [7:0] OP_BE64  = 8'hD8;
  localparam logic [7:0] OP_CE1   = 8'h60;
  localparam logic [7:0] OP_CE2   = 8'hC7;
  // Frame lengths in link clock bits
  localparam logic [7:0] BITS_OP   = 8'h08;
  localparam logic [7:0] BITS_ADDR = 8'h20;
  localparam logic [7:0] BITS_DATA = 8'h28;
  localparam logic [7:0] BITS_UID  = 8'hA8;
  localparam logic [7:0] UID_WRAP  = 8'hA7;
  // Security register geometry
  localparam logic [10:0] SR_BYTES   = 11'h400;
  localparam logic [10:0] PAGE_BYTES = 11'h100;
  localparam logic [3:0]  SR_SEL_MIN = 4'h1;
  localparam logic [3:0]  SR_SEL_MAX = 4'h3;
  // Timing, mclk at 10 MHz
  localparam int CLK_NS               = 100;
  localparam int SECREG_ERASE_TIME_US = 200;
  localparam int PAGE_WRITE_TIME_US   = 100;
  localparam int ARR_PROG_TIME_US     = 100;
  localparam int ARR_ERASE_TIME_US    = 300;
  localparam logic [15:0] SE_CYC = 16'((SECREG_ERASE_TIME_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] PP_CYC = 16'((PAGE_WRITE_TIME_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] AP_CYC = 16'((ARR_PROG_TIME_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] AE_CYC = 16'((ARR_ERASE_TIME_US * 1000 + CLK_NS - 1) / CLK_NS);
  // Reset values
  localparam logic [2:0] CS_SYNC_RST = 3'h7;
  localparam logic [1:0] SO_SYNC_RST = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_APROG  = 3'b001,
    ST_AERASE = 3'b010,
    ST_SPROG  = 3'b011,
    ST_SERASE = 3'b100,
    ST_PPROG  = 3'b101,
    ST_PERASE = 3'b110
  } fsr_dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_SHIFT = 2'b01,
    H_GAP   = 2'b10
  } fsr_host_state_t;
endpackage : fsr_pkg

// [fsr_if.sv]
// Serial link between the flash controller and the flash device
`timescale 1ns/1ps
interface fsr_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic so;

  modport dev (
    input  cs_n,
    input  sclk,
    input  si,
    output so
  );

  modport host (
    output cs_n,
    output sclk,
    output si,
    input  so
  );
endinterface : fsr_if

// [fsr_host.sv]
// Flash controller end: frames commands on the serial link and reads the unique id
`timescale 1ns/1ps
module fsr_host #(
  parameter logic [7:0] HALF_DIV = 8'h04,
  parameter logic [7:0] GAP_CYC  = 8'h08
) (
  fsr_if.host        link,
  input  wire logic  mclk,
  input  wire logic  rst_n,
  input  wire logic  cmd_valid,
  input  wire logic  [7:0] cmd_opcode,
  input  wire logic  [23:0] cmd_addr,
  input  wire logic  [7:0] cmd_data,
  output logic       cmd_ready,
  output logic       cmd_refused,
  output logic       [127:0] uid_data,
  output logic       uid_valid
);
  function automatic logic [7:0] frame_len(input logic [7:0] op);
    case (op)
      fsr_pkg::OP_UID:  return fsr_pkg::BITS_UID;
      fsr_pkg::OP_SRPG, fsr_pkg::OP_PP, fsr_pkg::OP_QPP: return fsr_pkg::BITS_DATA;
      fsr_pkg::OP_SRER, fsr_pkg::OP_SE, fsr_pkg::OP_BE32, fsr_pkg::OP_BE64: return fsr_pkg::BITS_ADDR;
      default: return fsr_pkg::BITS_OP;
    endcase
  endfunction : frame_len

  fsr_pkg::fsr_host_state_t st_r, st_nxt;
  logic [7:0]   div_r, div_nxt;
  logic [7:0]   bits_r, bits_nxt;
  logic [7:0]   tot_r, tot_nxt;
  logic [39:0]  tx_r, tx_nxt;
  logic [127:0] rx_nxt;
  logic         cs_n_r, cs_n_nxt;
  logic         sclk_r, sclk_nxt;
  logic         si_r, si_nxt;
  logic         ready_nxt, refused_nxt, uidv_nxt;
  logic         lat_r, lat_nxt;
  logic         pau_r, pau_nxt;
  logic         pprog_r, pprog_nxt;
  logic         lprog_r, lprog_nxt;
  logic [1:0]   so_s_r;
  logic         bad;
  logic         is_uid;

  assign is_uid = (cmd_opcode == fsr_pkg::OP_UID);
  assign bad = (pau_r && (cmd_opcode == fsr_pkg::OP_WRSR || cmd_opcode == fsr_pkg::OP_SRER ||
                cmd_opcode == fsr_pkg::OP_SE || cmd_opcode == fsr_pkg::OP_BE32 ||
                cmd_opcode == fsr_pkg::OP_BE64 || cmd_opcode == fsr_pkg::OP_CE1 ||
                cmd_opcode == fsr_pkg::OP_CE2)) ||
               (pau_r && pprog_r && (cmd_opcode == fsr_pkg::OP_SRPG ||
                cmd_opcode == fsr_pkg::OP_PP || cmd_opcode == fsr_pkg::OP_QPP)) ||
               ((cmd_opcode == fsr_pkg::OP_SRER || cmd_opcode == fsr_pkg::OP_SRPG) && !lat_r);

  always_comb begin
    st_nxt      = st_r;
    div_nxt     = div_r;
    bits_nxt    = bits_r;
    tot_nxt     = tot_r;
    tx_nxt      = tx_r;
    rx_nxt      = uid_data;
    cs_n_nxt    = cs_n_r;
    sclk_nxt    = sclk_r;
    si_nxt      = si_r;
    refused_nxt = 1'b0;
    uidv_nxt    = 1'b0;
    lat_nxt     = lat_r;
    pau_nxt     = pau_r;
    pprog_nxt   = pprog_r;
    lprog_nxt   = lprog_r;
    case (st_r)
      fsr_pkg::H_IDLE: begin
        if (cmd_valid) begin
          if (bad) begin
            refused_nxt = 1'b1;
          end else begin
            // Id read forces zero address and a zero dummy byte
            tx_nxt   = {cmd_opcode, is_uid ? 24'h000000 : cmd_addr, is_uid ? 8'h00 : cmd_data};
            si_nxt   = cmd_opcode[7];
            tot_nxt  = frame_len(cmd_opcode);
            bits_nxt = 8'h00;
            div_nxt  = 8'h00;
            cs_n_nxt = 1'b0;
            st_nxt   = fsr_pkg::H_SHIFT;
            case (cmd_opcode)
              fsr_pkg::OP_WENA:  lat_nxt = 1'b1;
              fsr_pkg::OP_PAUSE: begin
                pau_nxt   = 1'b1;
                pprog_nxt = lprog_r;
              end
              fsr_pkg::OP_CONT:  pau_nxt = 1'b0;
              fsr_pkg::OP_RST: begin
                pau_nxt = 1'b0;
                lat_nxt = 1'b0;
              end
              fsr_pkg::OP_PP, fsr_pkg::OP_QPP: begin
                lprog_nxt = 1'b1;
                lat_nxt   = 1'b0;
              end
              fsr_pkg::OP_SE, fsr_pkg::OP_BE32, fsr_pkg::OP_BE64, fsr_pkg::OP_CE1,
              fsr_pkg::OP_CE2: begin
                lprog_nxt = 1'b0;
                lat_nxt   = 1'b0;
              end
              fsr_pkg::OP_WRDI, fsr_pkg::OP_WRSR, fsr_pkg::OP_SRER,
              fsr_pkg::OP_SRPG:  lat_nxt = 1'b0;
              default: begin
              end
            endcase
          end
        end
      end
      fsr_pkg::H_SHIFT: begin
        if (div_r == 8'(HALF_DIV - 8'h01)) begin
          div_nxt = 8'h00;
          if (!sclk_r) begin
            sclk_nxt = 1'b1;
            // Synced copy lags by two cycles; HALF_DIV of three or more covers it
            if (tot_r == fsr_pkg::BITS_UID && bits_r >= fsr_pkg::BITS_DATA) begin
              rx_nxt = {uid_data[126:0], so_s_r[1]};
            end
          end else begin
            sclk_nxt = 1'b0;
            bits_nxt = 8'(bits_r + 8'h01);
            tx_nxt   = {tx_r[38:0], 1'b0};
            si_nxt   = tx_r[38];
            if (8'(bits_r + 8'h01) == tot_r) begin
              cs_n_nxt = 1'b1;
              st_nxt   = fsr_pkg::H_GAP;
              uidv_nxt = (tot_r == fsr_pkg::BITS_UID);
            end
          end
        end else begin
          div_nxt = 8'(div_r + 8'h01);
        end
      end
      fsr_pkg::H_GAP: begin
        // Deselect long enough for the device to see the frame end
        div_nxt = 8'(div_r + 8'h01);
        if (div_r == 8'(GAP_CYC - 8'h01)) begin
          st_nxt = fsr_pkg::H_IDLE;
        end
      end
      default: st_nxt = fsr_pkg::H_IDLE;
    endcase
    ready_nxt = (st_nxt == fsr_pkg::H_IDLE);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r        <= fsr_pkg::H_IDLE;
      div_r       <= 8'h00;
      bits_r      <= 8'h00;
      tot_r       <= 8'h00;
      tx_r        <= 40'h00_0000_0000;
      uid_data    <= '0;
      cs_n_r      <= 1'b1;
      sclk_r      <= 1'b0;
      si_r        <= 1'b0;
      cmd_ready   <= 1'b0;
      cmd_refused <= 1'b0;
      uid_valid   <= 1'b0;
      lat_r       <= 1'b0;
      pau_r       <= 1'b0;
      pprog_r     <= 1'b0;
      lprog_r     <= 1'b0;
      so_s_r      <= fsr_pkg::SO_SYNC_RST;
    end else begin
      st_r        <= st_nxt;
      div_r       <= div_nxt;
      bits_r      <= bits_nxt;
      tot_r       <= tot_nxt;
      tx_r        <= tx_nxt;
      uid_data    <= rx_nxt;
      cs_n_r      <= cs_n_nxt;
      sclk_r      <= sclk_nxt;
      si_r        <= si_nxt;
      cmd_ready   <= ready_nxt;
      cmd_refused <= refused_nxt;
      uid_valid   <= uidv_nxt;
      lat_r       <= lat_nxt;
      pau_r       <= pau_nxt;
      pprog_r     <= pprog_nxt;
      lprog_r     <= lprog_nxt;
      so_s_r      <= {so_s_r[0], link.so};
    end
  end

  assign link.cs_n = cs_n_r;
  assign link.sclk = sclk_r;
  assign link.si   = si_r;
endmodule : fsr_host

// [fsr_checker.sv]
// Checker on the serial link and the device status flags
`timescale 1ns/1ps
module fsr_checker (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic       si,
  input wire logic       busy_flag,
  input wire logic       write_latch,
  input wire logic [1:0] paused_flags
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic       sclk_q_r, sclk_q_nxt;
  logic [3:0] nbit_r, nbit_nxt;
  logic [7:0] op_r, op_nxt;

  // First byte of each frame, so a software reset is not taken for a failed resume
  always_comb begin
    sclk_q_nxt = sclk;
    nbit_nxt   = cs_n ? 4'h0 : nbit_r;
    op_nxt     = op_r;
    if (!cs_n && sclk && !sclk_q_r && nbit_r < 4'h8) begin
      op_nxt   = {op_r[6:0], si};
      nbit_nxt = 4'(nbit_r + 4'h1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q_r <= 1'b0;
      nbit_r   <= 4'h0;
      op_r     <= 8'h00;
    end else begin
      sclk_q_r <= sclk_q_nxt;
      nbit_r   <= nbit_nxt;
      op_r     <= op_nxt;
    end
  end

  idle_sclk_a: assert property (cs_n |-> !sclk)
    else $error("link clock moves while deselected");
  si_low_phase_a: assert property ($changed(si) |-> !sclk)
    else $error("serial input changed while link clock high");
  one_pause_a: assert property (paused_flags != 2'h3)
    else $error("both paused flags set");
  pause_needs_busy_a: assert property ($rose(|paused_flags) |-> $past(busy_flag))
    else $error("pause taken while not busy");
  pause_drops_busy_a: assert property ($rose(|paused_flags) |-> !busy_flag)
    else $error("busy still set after pause");
  resume_busy_a: assert property ($fell(|paused_flags) && op_r != fsr_pkg::OP_RST
    |-> busy_flag)
    else $error("busy not raised on resume");
  soft_reset_clear_a: assert property ($fell(|paused_flags) && op_r == fsr_pkg::OP_RST
    |-> !busy_flag && !write_latch)
    else $error("software reset left busy or write latch set");
  flag_from_frame_a: assert property ($changed(paused_flags) |-> cs_n && $past(cs_n))
    else $error("paused flags moved inside a frame");
  latch_clear_a: assert property ($rose(busy_flag) && $past(write_latch)
    && !$past(|paused_flags) |-> !write_latch)
    else $error("write latch kept at start of secure write");
endmodule : fsr_checker

// [fsr_bench.sv]
// Bench joining host and device ends over the serial link
`timescale 1ns/1ps
module flash_suspend_resume_secreg_bench;
  // Arbitrary id value
  localparam logic [127:0] UID_EXP = 128'h5A5A0123456789ABCDEFFEDCBA987654;
  logic         mclk           = 1'h0;
  logic         rst_n          = 1'h0;
  logic         cmd_valid      = 1'h0;
  logic [7:0]   cmd_opcode     = 8'h00;
  logic [23:0]  cmd_addr       = 24'h000000;
  logic [7:0]   cmd_data       = 8'h00;
  logic [2:0]   otp_lock_bits  = 3'h0;
  logic         array_op_start = 1'h0;
  logic         array_op_erase = 1'h0;
  logic [1:0]   rd_sel         = 2'h0;
  logic [9:0]   rd_off         = 10'h000;
  logic [7:0]   rd_data;
  logic         busy_flag;
  logic         write_latch;
  logic [1:0]   paused_flags;
  logic         cmd_ready;
  logic         cmd_refused;
  logic [127:0] uid_data;
  logic         uid_valid;
  logic         uid_seen       = 1'h0;
  logic         ref_r;
  int           failures       = 0;
  int           check_count    = 0;
  int           cyc            = 0;
  int           n;
  fsr_if link ();
  fsr_device #(.UID_VALUE(UID_EXP)) u_fsr_device (.link(link), .mclk(mclk), .rst_n(rst_n),
    .otp_lock_bits(otp_lock_bits), .array_op_start(array_op_start),
    .array_op_erase(array_op_erase), .rd_sel(rd_sel), .rd_off(rd_off), .rd_data(rd_data),
    .busy_flag(busy_flag), .write_latch(write_latch), .paused_flags(paused_flags));
  fsr_host u_fsr_host (.link(link), .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .cmd_refused(cmd_refused), .uid_data(uid_data),
    .uid_valid(uid_valid));
  fsr_checker u_fsr_checker (.mclk(mclk), .rst_n(rst_n), .cs_n(link.cs_n), .sclk(link.sclk),
    .si(link.si), .busy_flag(busy_flag), .write_latch(write_latch),
    .paused_flags(paused_flags));

  always #50 mclk = ~mclk;

  task automatic final_report();
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  // Ceiling well above the longest self-timed sequence
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (uid_valid === 1'h1) uid_seen <= 1'h1;
    if (cyc == 40000) begin
      failures++;
      final_report();
    end
  end

  task automatic chk(input string name, input logic [127:0] e, input logic [127:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic send(input logic [7:0] op, input logic [23:0] ad, input logic [7:0] dt);
    int k;
    for (k = 0; k < 4000 && cmd_ready !== 1'h1; k++) begin @(posedge mclk); #1; end
    @(posedge mclk);
    cmd_opcode <= op;
    cmd_addr <= ad;
    cmd_data <= dt;
    cmd_valid <= 1'h1;
    @(posedge mclk);
    cmd_valid <= 1'h0;
    #1;
    ref_r = cmd_refused;
    @(posedge mclk);
    #1;
    ref_r = ref_r | cmd_refused;
    for (k = 0; k < 4000 && cmd_ready !== 1'h1; k++) begin @(posedge mclk); #1; end
    // Device sees the frame end a few cycles after deselect
    repeat (4) @(posedge mclk);
    #1;
  endtask : send

  task automatic flags(input logic b, input logic l, input logic [1:0] p);
    chk("busy_flag", 128'(b), 128'(busy_flag));
    chk("write_latch", 128'(l), 128'(write_latch));
    chk("paused_flags", 128'(p), 128'(paused_flags));
  endtask : flags

  task automatic wait_busy(output int c);
    for (c = 0; c < 5000 && busy_flag === 1'h1; c++) begin @(posedge mclk); #1; end
  endtask : wait_busy

  task automatic rdchk(input logic [1:0] s, input logic [9:0] o, input logic [7:0] e);
    @(posedge mclk);
    rd_sel <= s;
    rd_off <= o;
    repeat (2) @(posedge mclk);
    #1;
    chk("rd_data", 128'(e), 128'(rd_data));
  endtask : rdchk

  task automatic arr(input logic er);
    @(posedge mclk);
    array_op_erase <= er;
    array_op_start <= 1'h1;
    @(posedge mclk);
    array_op_start <= 1'h0;
    repeat (2) @(posedge mclk);
    #1;
  endtask : arr

  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'h1;
    send(fsr_pkg::OP_UID, 24'h000000, 8'h00);
    chk("uid_valid", 128'h1, 128'(uid_seen));
    chk("uid_data", UID_EXP, uid_data);
    send(fsr_pkg::OP_SRER, 24'h001000, 8'h00);
    chk("refused", 128'h1, 128'(ref_r));
    flags(1'h0, 1'h0, 2'h0);
    send(fsr_pkg::OP_WENA, 24'h000000, 8'h00);
    flags(1'h0, 1'h1, 2'h0);
    send(fsr_pkg::OP_SRER, 24'h001000, 8'h00);
    flags(1'h1, 1'h0, 2'h0);
    wait_busy(n);
    chk("erase_time", 128'h1, 128'(n > 1900 && n <= int'(fsr_pkg::SE_CYC)));
    rdchk(2'h1, 10'h3FF, 8'hFF);
    send(fsr_pkg::OP_WENA, 24'h000000, 8'h00);
    send(fsr_pkg::OP_SRPG, 24'h0013FF, 8'hA5);
    flags(1'h1, 1'h0, 2'h0);
    wait_busy(n);
    chk("prog_time", 128'h1, 128'(n > 900 && n <= int'(fsr_pkg::PP_CYC)));
    rdchk(2'h1, 10'h3FF, 8'hA5);
    rdchk(2'h1, 10'h2FF, 8'hFF);
    // Lock stays on: it models a one-time fuse
    @(posedge mclk);
    otp_lock_bits <= 3'h1;
    send(fsr_pkg::OP_WENA, 24'h000000, 8'h00);
    send(fsr_pkg::OP_SRER, 24'h001000, 8'h00);
    flags(1'h0, 1'h1, 2'h0);
    // Host spends its latch on every erase frame, refused or not by the device
    send(fsr_pkg::OP_WENA, 24'h000000, 8'h00);
    send(fsr_pkg::OP_SRER, 24'h002000, 8'h00);
    flags(1'h1, 1'h0, 2'h0);
    wait_busy(n);
    rdchk(2'h1, 10'h3FF, 8'hA5);
    rdchk(2'h2, 10'h000, 8'hFF);
    send(fsr_pkg::OP_CONT, 24'h000000, 8'h00);
    flags(1'h0, 1'h0, 2'h0);
    send(fsr_pkg::OP_PAUSE, 24'h000000, 8'h00);
    flags(1'h0, 1'h0, 2'h0);
    arr(1'h1);
    flags(1'h1, 1'h0, 2'h0);
    send(fsr_pkg::OP_PAUSE, 24'h000000, 8'h00);
    flags(1'h0, 1'h0, 2'h1);
    send(fsr_pkg::OP_SE, 24'h000000, 8'h00);
    chk("refused", 128'h1, 128'(ref_r));
    send(fsr_pkg::OP_PAUSE, 24'h000000, 8'h00);
    flags(1'h0, 1'h0, 2'h1);
    send(fsr_pkg::OP_CONT, 24'h000000, 8'h00);
    flags(1'h1, 1'h0, 2'h0);
    wait_busy(n);
    chk("busy_done", 128'h0, 128'(busy_flag));
    send(fsr_pkg::OP_PP, 24'h000000, 8'h00);
    arr(1'h0);
    send(fsr_pkg::OP_PAUSE, 24'h000000, 8'h00);
    flags(1'h0, 1'h0, 2'h2);
    send(fsr_pkg::OP_WRSR, 24'h000000, 8'h00);
    chk("refused", 128'h1, 128'(ref_r));
    send(fsr_pkg::OP_QPP, 24'h000000, 8'h00);
    chk("refused", 128'h1, 128'(ref_r));
    // Power loss in mid-pause
    @(posedge mclk);
    rst_n <= 1'h0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (2) @(posedge mclk);
    #1;
    flags(1'h0, 1'h0, 2'h0);
    // Software reset out of a paused erase with the latch set
    arr(1'h1);
    send(fsr_pkg::OP_PAUSE, 24'h000000, 8'h00);
    send(fsr_pkg::OP_WENA, 24'h000000, 8'h00);
    flags(1'h0, 1'h1, 2'h1);
    send(fsr_pkg::OP_RSTEN, 24'h000000, 8'h00);
    send(fsr_pkg::OP_RST, 24'h000000, 8'h00);
    flags(1'h0, 1'h0, 2'h0);
    final_report();
  end
endmodule : flash_suspend_resume_secreg_bench
